//--- hdl/iocd_pkg.sv
// Constants, types and shared decode functions of the IO module command decoder
package iocd_pkg;

  // Command register addresses
  localparam logic [15:0] ADDR_CODE      = 16'h1F3F;
  localparam logic [15:0] ADDR_LEN       = 16'h1F40;
  localparam logic [15:0] ADDR_DEST      = 16'h1F41;
  localparam logic [15:0] ADDR_SEC       = 16'h1F42;
  localparam logic [15:0] ADDR_PWD_HI    = 16'h1F43;
  localparam logic [15:0] ADDR_PWD_LO    = 16'h1F44;
  localparam logic [15:0] ADDR_ARG       = 16'h1F45;
  localparam logic [15:0] ADDR_METHOD    = 16'h1F46;
  localparam logic [15:0] ADDR_SEQ_HI    = 16'h1F4B;
  localparam logic [15:0] ADDR_SEQ_LO    = 16'h1F4C;
  localparam logic [15:0] ADDR_SEV       = 16'h1F4D;
  localparam logic [15:0] ADDR_LAST_CODE = 16'h1F53;
  localparam logic [15:0] ADDR_STATUS    = 16'h1F54;

  // Command codes (41100, 41102, 42890, 50560) and parameter byte counts
  localparam logic [15:0] CMD_SIMPLE = 16'hA08C;
  localparam logic [15:0] CMD_RELAY  = 16'hA08E;
  localparam logic [15:0] CMD_ANALOG = 16'hA78A;
  localparam logic [15:0] CMD_EVENTS = 16'hC580;
  localparam logic [15:0] LEN_SIMPLE = 16'h000B;
  localparam logic [15:0] LEN_RELAY  = 16'h000B;
  localparam logic [15:0] LEN_ANALOG = 16'h000A;
  localparam logic [15:0] LEN_EVENTS = 16'h001B;

  // Destinations and security types
  localparam logic [15:0] DEST_IO1 = 16'h2001;
  localparam logic [15:0] DEST_IO2 = 16'h2101;
  localparam logic [15:0] SEC_NONE = 16'h0000;
  localparam logic [15:0] SEC_PWD  = 16'h0001;

  // Argument encodings (upper byte of the argument word)
  localparam logic [7:0] ARG_DISABLE     = 8'h00;
  localparam logic [7:0] ARG_ENABLE      = 8'h01;
  localparam logic [7:0] ARG_RELAY_FIRST = 8'h01;
  localparam logic [7:0] ARG_RELAY_LAST  = 8'h03;
  localparam logic [7:0] ARG_UNLATCH_ALL = 8'hFF;

  // Event request fields
  localparam logic [15:0] METHOD_RECENT = 16'h0000;
  localparam logic [15:0] METHOD_BEFORE = 16'h0002;
  localparam int          SEV_LOW_BIT   = 8;
  localparam int          SEV_HIGH_BIT  = 10;
  localparam logic [3:0]  EVT_MAX_COUNT = 4'hA;

  // Command status words
  localparam logic [15:0] STAT_OK       = 16'h0000;
  localparam logic [15:0] STAT_BAD_CODE = 16'h0001;
  localparam logic [15:0] STAT_BAD_LEN  = 16'h0002;
  localparam logic [15:0] STAT_BAD_DEST = 16'h0003;
  localparam logic [15:0] STAT_BAD_SEC  = 16'h0004;
  localparam logic [15:0] STAT_BAD_PWD  = 16'h0005;
  localparam logic [15:0] STAT_BAD_ARG  = 16'h0006;

  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic {
    IOCD_ST_IDLE = 1'b0,
    IOCD_ST_EXEC = 1'b1
  } iocd_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iocd_bus_t;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] len;
    logic [15:0] dest;
    logic [15:0] sec;
    logic [31:0] pwd;
    logic [15:0] arg;
    logic [15:0] method;
    logic [31:0] seq;
    logic [15:0] sev;
  } iocd_frame_t;

  typedef struct packed {
    logic        valid;
    logic        before_seq;
    logic [31:0] seq;
    logic [2:0]  sev_mask;
    logic [3:0]  max_count;
  } iocd_evt_req_t;

  typedef struct packed {
    iocd_state_t   st;
    iocd_frame_t   frame;
    logic          simple_en;
    logic [2:0]    unlatch;
    logic          minmax_clr;
    iocd_evt_req_t evt;
    logic          target;
    logic          done;
    logic [15:0]   last_code;
    logic [15:0]   status;
    logic [15:0]   rdata;
    logic          rvalid;
  } iocd_regs_t;

  function automatic logic iocd_dest_ok(input logic [15:0] dest);
    return (dest == DEST_IO1) || (dest == DEST_IO2);
  endfunction

  function automatic logic iocd_pwd_ok(input logic [31:0] pwd, input logic [31:0] admin,
                                       input logic [31:0] oper);
    return (pwd == admin) || (pwd == oper);
  endfunction

endpackage

//--- hdl/iocd_check.sv
// Frame validator: maps a command frame to its completion status word
`timescale 1ns/10ps
module iocd_check (
  // Frame and credentials
  input  wire iocd_pkg::iocd_frame_t frame,
  input  wire logic [31:0]           admin_pwd,
  input  wire logic [31:0]           oper_pwd,
  // Verdict
  output      logic [15:0]           status
);
  import iocd_pkg::*;

  logic [7:0]  arg_hi;
  logic [15:0] want_len;
  logic        prot;
  logic        arg_ok;

  always_comb begin
    arg_hi   = frame.arg[15:8];
    want_len = WORD_RESET;
    prot     = 1'b1;
    arg_ok   = 1'b1;
    unique case (frame.code)
      CMD_SIMPLE: begin
        want_len = LEN_SIMPLE;
        arg_ok   = (arg_hi == ARG_DISABLE) || (arg_hi == ARG_ENABLE);
      end
      CMD_RELAY: begin
        want_len = LEN_RELAY;
        arg_ok   = ((arg_hi >= ARG_RELAY_FIRST) && (arg_hi <= ARG_RELAY_LAST)) || (arg_hi == ARG_UNLATCH_ALL);
      end
      CMD_ANALOG: begin
        want_len = LEN_ANALOG;
      end
      CMD_EVENTS: begin
        want_len = LEN_EVENTS;
        prot     = 1'b0;
        arg_ok   = (frame.method == METHOD_RECENT) || (frame.method == METHOD_BEFORE);
      end
      default: begin
        want_len = WORD_RESET;
      end
    endcase
    if (!((frame.code == CMD_SIMPLE) || (frame.code == CMD_RELAY) ||
          (frame.code == CMD_ANALOG) || (frame.code == CMD_EVENTS)))
      status = STAT_BAD_CODE;
    else if (frame.len != want_len)
      status = STAT_BAD_LEN;
    else if (!iocd_dest_ok(frame.dest))
      status = STAT_BAD_DEST;
    else if (prot && (frame.sec != SEC_PWD))
      status = STAT_BAD_SEC;
    else if (prot && !iocd_pwd_ok(frame.pwd, admin_pwd, oper_pwd))
      status = STAT_BAD_PWD;
    else if (!arg_ok)
      status = STAT_BAD_ARG;
    else
      status = STAT_OK;
  end

endmodule

//--- hdl/iocd_top.sv
// IO module command decoder: command register block, execution and status report
`timescale 1ns/10ps

module iocd_top (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Register access from the fieldbus side
  input  wire iocd_pkg::iocd_bus_t     bus,
  input  wire logic                    cmd_exec,
  output      logic [15:0]             reg_rdata,
  output      logic                    reg_rvalid,
  // Credentials
  input  wire logic [31:0]             admin_pwd,
  input  wire logic [31:0]             oper_pwd,
  // Actions
  output      logic                    simple_cmd_en,
  output      logic [2:0]              relay_unlatch,
  output      logic                    ain_minmax_clr,
  output      iocd_pkg::iocd_evt_req_t evt_req,
  output      logic                    target_io2,
  // Completion
  output      logic                    cmd_done,
  output      logic [15:0]             last_cmd_code,
  output      logic [15:0]             cmd_status
);
  import iocd_pkg::*;

  iocd_regs_t q_reg;
  iocd_regs_t q_next;
  logic [15:0] chk_status;
  logic [7:0]  arg_hi;

  iocd_check u_check (
    .frame     (q_reg.frame),
    .admin_pwd (admin_pwd),
    .oper_pwd  (oper_pwd),
    .status    (chk_status)
  );

  assign arg_hi = q_reg.frame.arg[15:8];

  always_comb begin
    q_next            = q_reg;
    q_next.unlatch    = 3'h0;
    q_next.minmax_clr = 1'b0;
    q_next.evt.valid  = 1'b0;
    q_next.done       = 1'b0;
    q_next.rvalid     = bus.rd;
    q_next.rdata      = WORD_RESET;
    // Command words are write-only; only the report words read back
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_LAST_CODE: q_next.rdata = q_reg.last_code;
        ADDR_STATUS:    q_next.rdata = q_reg.status;
        default:        q_next.rdata = WORD_RESET;
      endcase
    end
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_CODE:   q_next.frame.code = bus.wdata;
        ADDR_LEN:    q_next.frame.len = bus.wdata;
        ADDR_DEST:   q_next.frame.dest = bus.wdata;
        ADDR_SEC:    q_next.frame.sec = bus.wdata;
        ADDR_PWD_HI: q_next.frame.pwd[31:16] = bus.wdata;
        ADDR_PWD_LO: q_next.frame.pwd[15:0] = bus.wdata;
        ADDR_ARG:    q_next.frame.arg = bus.wdata;
        ADDR_METHOD: q_next.frame.method = bus.wdata;
        ADDR_SEQ_HI: q_next.frame.seq[31:16] = bus.wdata;
        ADDR_SEQ_LO: q_next.frame.seq[15:0] = bus.wdata;
        ADDR_SEV:    q_next.frame.sev = bus.wdata;
        default:     q_next.frame = q_reg.frame;
      endcase
    end
    unique case (q_reg.st)
      IOCD_ST_IDLE: begin
        if (cmd_exec)
          q_next.st = IOCD_ST_EXEC;
      end
      IOCD_ST_EXEC: begin
        q_next.st        = IOCD_ST_IDLE;
        q_next.done      = 1'b1;
        q_next.last_code = q_reg.frame.code;
        q_next.status    = chk_status;
        if (chk_status == STAT_OK) begin
          q_next.target = (q_reg.frame.dest == DEST_IO2);
          unique case (q_reg.frame.code)
            CMD_SIMPLE: q_next.simple_en = (arg_hi == ARG_ENABLE);
            CMD_RELAY: begin
              if (arg_hi == ARG_UNLATCH_ALL)
                q_next.unlatch = 3'h7;
              else
                q_next.unlatch = 3'(3'h1 << (arg_hi - ARG_RELAY_FIRST));
            end
            CMD_ANALOG: q_next.minmax_clr = 1'b1;
            CMD_EVENTS: begin
              q_next.evt.valid      = 1'b1;
              q_next.evt.before_seq = (q_reg.frame.method == METHOD_BEFORE);
              q_next.evt.seq        = (q_reg.frame.method == METHOD_BEFORE) ? q_reg.frame.seq : 32'h0;
              q_next.evt.sev_mask   = q_reg.frame.sev[SEV_HIGH_BIT:SEV_LOW_BIT];
              q_next.evt.max_count  = EVT_MAX_COUNT;
            end
            default: q_next.done = 1'b1;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  assign reg_rdata      = q_reg.rdata;
  assign reg_rvalid     = q_reg.rvalid;
  assign simple_cmd_en  = q_reg.simple_en;
  assign relay_unlatch  = q_reg.unlatch;
  assign ain_minmax_clr = q_reg.minmax_clr;
  assign evt_req        = q_reg.evt;
  assign target_io2     = q_reg.target;
  assign cmd_done       = q_reg.done;
  assign last_cmd_code  = q_reg.last_code;
  assign cmd_status     = q_reg.status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence seq_exec_start;
    (q_reg.st == IOCD_ST_IDLE) && cmd_exec;
  endsequence

  sequence seq_done_ok(logic [15:0] code);
    q_reg.done && (q_reg.status == STAT_OK) && (q_reg.last_code == code);
  endsequence

  chk_exec_report: assert property (seq_exec_start |-> ##2 q_reg.done)
    else $error("command completion missing two cycles after exec");
  chk_report_code: assert property (q_reg.done |-> q_reg.last_code == $past(q_reg.frame.code))
    else $error("reported code differs from the executed frame");
  chk_minmax_cause: assert property (q_reg.minmax_clr |-> seq_done_ok(CMD_ANALOG))
    else $error("analog extremes cleared without a valid reset command");
  chk_unlatch_cause: assert property (|q_reg.unlatch |-> seq_done_ok(CMD_RELAY))
    else $error("relay unlatched without a valid acknowledge");
  chk_simple_cause: assert property ($changed(q_reg.simple_en) |-> seq_done_ok(CMD_SIMPLE))
    else $error("simple command enable changed without a valid toggle");
  chk_dest_valid: assert property (q_reg.done && (q_reg.status == STAT_OK) |->
                                   iocd_dest_ok($past(q_reg.frame.dest)))
    else $error("command accepted with a foreign destination");
  chk_pwd_gate: assert property (q_reg.done && (q_reg.status == STAT_OK) && (q_reg.last_code != CMD_EVENTS) |->
                                 iocd_pwd_ok($past(q_reg.frame.pwd), $past(admin_pwd), $past(oper_pwd)))
    else $error("protected command accepted with a wrong password");
  chk_evt_method: assert property (q_reg.evt.valid |->
                                   ($past(q_reg.frame.method) == METHOD_RECENT) ||
                                   ($past(q_reg.frame.method) == METHOD_BEFORE))
    else $error("event request issued for an invalid method");
  chk_seq_ignored: assert property (q_reg.evt.valid && !q_reg.evt.before_seq |-> q_reg.evt.seq == 32'h0)
    else $error("sequence number passed for the recent method");
  chk_evt_limit: assert property (q_reg.evt.valid |-> (q_reg.evt.max_count == EVT_MAX_COUNT) &&
                                  (q_reg.evt.sev_mask == $past(q_reg.frame.sev[SEV_HIGH_BIT:SEV_LOW_BIT])))
    else $error("event request limit or severity mask wrong");
  // Sequence number is carried through unchanged when the before-sequence method is accepted
  chk_seq_passed: assert property (q_reg.evt.valid && q_reg.evt.before_seq |->
                                   q_reg.evt.seq == $past(q_reg.frame.seq))
    else $error("sequence number lost for the before-sequence method");

  // Report words answer one cycle after the read strobe; command words read as zero
  chk_read_valid: assert property (bus.rd |=> q_reg.rvalid)
    else $error("read strobe not answered in the next cycle");
  chk_read_status: assert property (bus.rd && (bus.addr == ADDR_STATUS) |=>
                                    q_reg.rdata == $past(q_reg.status))
    else $error("status word read back wrong");
  chk_read_code: assert property (bus.rd && (bus.addr == ADDR_LAST_CODE) |=>
                                  q_reg.rdata == $past(q_reg.last_code))
    else $error("last command code read back wrong");
  chk_read_cmd_zero: assert property (bus.rd && (bus.addr != ADDR_STATUS) && (bus.addr != ADDR_LAST_CODE) |=>
                                      q_reg.rdata == WORD_RESET)
    else $error("command word read back nonzero");

  // Completion is a single pulse and the executor is never busy for longer than one cycle
  chk_done_pulse: assert property (q_reg.done |=> !q_reg.done)
    else $error("completion pulse longer than one cycle");
  chk_exec_once: assert property ((q_reg.st == IOCD_ST_EXEC) |=> (q_reg.st == IOCD_ST_IDLE))
    else $error("executor busy for more than one cycle");
  chk_reject_quiet: assert property (q_reg.done && (q_reg.status != STAT_OK) |->
                                     !(|q_reg.unlatch) && !q_reg.minmax_clr && !q_reg.evt.valid)
    else $error("rejected command still produced an action");
  chk_target_dest: assert property (q_reg.done && (q_reg.status == STAT_OK) |->
                                    q_reg.target == ($past(q_reg.frame.dest) == DEST_IO2))
    else $error("target module differs from the accepted destination");
  chk_simple_value: assert property (seq_done_ok(CMD_SIMPLE) |->
                                     q_reg.simple_en == ($past(arg_hi) == ARG_ENABLE))
    else $error("simple command enable differs from the argument");

  // Relay mask must match the argument code that was executed
  chk_unlatch_all: assert property ((&q_reg.unlatch) |->
                                    $past(arg_hi) == ARG_UNLATCH_ALL)
    else $error("all relays unlatched without the unlatch-all code");
  chk_unlatch_first: assert property (q_reg.unlatch[0] && !q_reg.unlatch[1] |->
                                      $past(arg_hi) == ARG_RELAY_FIRST)
    else $error("first relay unlatched for another code");
  chk_unlatch_last: assert property (q_reg.unlatch[2] && !q_reg.unlatch[1] |->
                                     $past(arg_hi) == ARG_RELAY_LAST)
    else $error("last relay unlatched for another code");

endmodule

//--- test/iocd_master.sv
// Register bus master model that writes command frames and reads status words
`timescale 1ns/10ps
module iocd_master (
  // Clock
  input  wire logic                clk,
  // Bus toward the decoder
  output      iocd_pkg::iocd_bus_t bus,
  output      logic                cmd_exec,
  input  wire logic [15:0]         reg_rdata,
  input  wire logic                reg_rvalid
);
  import iocd_pkg::*;

  initial begin
    bus = '0;
    cmd_exec = 1'b0;
  end

  // Each task starts just after an edge; wr and rd hold their request over the next edge, exec holds cmd_exec over n edges
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [16:0] r);
    bus = '{1'b0, 1'b1, a, ~bus.wdata};
    @(posedge clk);
    #1;
    r = {reg_rvalid, reg_rdata};
  endtask

  // Released address and data lines show the inverse of their last value
  task automatic exec(input int n);
    bus = '{1'b0, 1'b0, ~bus.addr, ~bus.wdata};
    cmd_exec = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    cmd_exec = 1'b0;
  endtask
endmodule

//--- test/io_module_command_decoder_test.sv
// Self-checking bench of the IO module command decoder
`timescale 1ns/10ps
module io_module_command_decoder_test;
  import iocd_pkg::*;
  typedef struct packed {
    iocd_frame_t   f;
    logic [15:0]   st;
    logic [6:0]    act;
    iocd_evt_req_t ev;
  } iocd_row_t;
  localparam logic [31:0]   ADM = 32'h1234_5678;
  localparam logic [31:0]   OPR = 32'h9ABC_DEF0;
  localparam iocd_evt_req_t EV0 = '0;

  logic          clk;
  logic          sys_rst;
  iocd_bus_t     bus;
  logic          cmd_exec;
  logic [15:0]   reg_rdata;
  logic          reg_rvalid;
  logic          simple_cmd_en;
  logic [2:0]    relay_unlatch;
  logic          ain_minmax_clr;
  iocd_evt_req_t evt_req;
  logic          target_io2;
  logic          cmd_done;
  logic [15:0]   last_cmd_code;
  logic [15:0]   cmd_status;
  int            errors = 0;
  int            checks = 0;
  iocd_row_t     rows [18];
  logic [16:0]   rr;

  iocd_top dut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .cmd_exec(cmd_exec), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .admin_pwd(ADM), .oper_pwd(OPR), .simple_cmd_en(simple_cmd_en),
    .relay_unlatch(relay_unlatch), .ain_minmax_clr(ain_minmax_clr), .evt_req(evt_req),
    .target_io2(target_io2), .cmd_done(cmd_done), .last_cmd_code(last_cmd_code), .cmd_status(cmd_status));

  iocd_master m (.clk(clk), .bus(bus), .cmd_exec(cmd_exec), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rst();
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Writes every frame word, then holds the execute strobe n cycles; returns with cmd_done visible
  task automatic send(input iocd_frame_t f, input int n);
    logic [15:0] a [11];
    logic [15:0] v [11];
    a = '{ADDR_CODE, ADDR_LEN, ADDR_DEST, ADDR_SEC, ADDR_PWD_HI, ADDR_PWD_LO, ADDR_ARG, ADDR_METHOD,
          ADDR_SEQ_HI, ADDR_SEQ_LO, ADDR_SEV};
    v = '{f.code, f.len, f.dest, f.sec, f.pwd[31:16], f.pwd[15:0], f.arg, f.method, f.seq[31:16],
          f.seq[15:0], f.sev};
    for (int i = 0; i < 11; i++) m.wr(a[i], v[i]);
    m.exec(n);
    repeat (2 - n) begin
      @(posedge clk);
      #1;
    end
  endtask

  initial begin
    #100000;
    errors++;
    close_out();
  end

  initial begin
    rows[0] = '{'{16'hA08C, 16'hB, 16'h2001, 16'h1, ADM, 16'h01A5, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h40, EV0};
    rows[1] = '{'{16'hA08E, 16'hB, 16'h2001, 16'h1, OPR, 16'h0100, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h48, EV0};
    rows[2] = '{'{16'hA08E, 16'hB, 16'h2101, 16'h1, ADM, 16'h0200, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h51, EV0};
    rows[3] = '{'{16'hA08E, 16'hB, 16'h2001, 16'h1, ADM, 16'h0300, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h60, EV0};
    rows[4] = '{'{16'hA08E, 16'hB, 16'h2001, 16'h1, ADM, 16'hFF00, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h78, EV0};
    rows[5] = '{'{16'hA08E, 16'hB, 16'h2001, 16'h1, ADM, 16'h0000, 16'h0, 32'h0, 16'h0}, 16'h6, 7'h40, EV0};
    rows[6] = '{'{16'hA08C, 16'hB, 16'h2001, 16'h1, ADM, 16'h0200, 16'h0, 32'h0, 16'h0}, 16'h6, 7'h40, EV0};
    rows[7] = '{'{16'hA08C, 16'hB, 16'h2101, 16'h1, OPR, 16'h0000, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h01, EV0};
    rows[8] = '{'{16'hA78A, 16'hA, 16'h2001, 16'h1, ADM, 16'h0, 16'h0, 32'h0, 16'h0}, 16'h0, 7'h04, EV0};
    rows[9] = '{'{16'hA78A, 16'hA, 16'h2001, 16'h1, 32'h0, 16'h0, 16'h0, 32'h0, 16'h0}, 16'h5, 7'h00, EV0};
    rows[10] = '{'{16'hA78A, 16'hA, 16'h2001, 16'h0, ADM, 16'h0, 16'h0, 32'h0, 16'h0}, 16'h4, 7'h00, EV0};
    rows[11] = '{'{16'hA78A, 16'hA, 16'h2002, 16'h1, ADM, 16'h0, 16'h0, 32'h0, 16'h0}, 16'h3, 7'h00, EV0};
    rows[12] = '{'{16'hA78A, 16'hB, 16'h2001, 16'h1, ADM, 16'h0, 16'h0, 32'h0, 16'h0}, 16'h2, 7'h00, EV0};
    rows[13] = '{'{16'hA08B, 16'hA, 16'h2001, 16'h1, ADM, 16'h0, 16'h0, 32'h0, 16'h0}, 16'h1, 7'h00, EV0};
    rows[14] = '{'{16'hC580, 16'h1B, 16'h2001, 16'h0, 32'h0, 16'h0, 16'h0, 32'h5555AAAA, 16'hFFFF}, 16'h0, 7'h02,
                 '{1'b1, 1'b0, 32'h0, 3'h7, 4'hA}};
    rows[15] = '{'{16'hC580, 16'h1B, 16'h2101, 16'h1, 32'h77777777, 16'h0, 16'h2, 32'hDEADBEEF, 16'h0200}, 16'h0,
                 7'h03, '{1'b1, 1'b1, 32'hDEADBEEF, 3'h2, 4'hA}};
    rows[16] = '{'{16'hC580, 16'h1B, 16'h2001, 16'h0, 32'h0, 16'h0, 16'h1, 32'h0, 16'h0100}, 16'h6, 7'h01, EV0};
    rows[17] = '{'{16'hC580, 16'h1A, 16'h2001, 16'h0, 32'h0, 16'h0, 16'h0, 32'h0, 16'h0100}, 16'h2, 7'h01, EV0};
    rst();
    chk({simple_cmd_en, relay_unlatch, ain_minmax_clr, evt_req, target_io2, cmd_done, last_cmd_code, cmd_status}, 0);
    foreach (rows[i]) begin
      send(rows[i].f, 1);
      chk(cmd_done, 1'b1);
      chk(last_cmd_code, rows[i].f.code);
      chk(cmd_status, rows[i].st);
      chk({simple_cmd_en, relay_unlatch, ain_minmax_clr, evt_req.valid, target_io2}, rows[i].act);
      if (rows[i].act[1]) chk(evt_req, rows[i].ev);
      m.rd(ADDR_STATUS, rr);
      chk(rr, {1'b1, rows[i].st});
      chk({cmd_done, relay_unlatch, ain_minmax_clr, evt_req.valid}, 6'h00);
      m.rd(ADDR_LAST_CODE, rr);
      chk(rr, {1'b1, rows[i].f.code});
    end
    m.rd(ADDR_LEN, rr);
    chk(rr, 17'h10000);
    // A write to a report word is ignored; the last status still reads back
    m.wr(ADDR_STATUS, 16'hBEEF);
    m.rd(ADDR_STATUS, rr);
    chk(rr, {1'b1, rows[17].st});
    send(rows[8].f, 2);
    chk({cmd_done, ain_minmax_clr}, 2'b11);
    repeat (3) begin
      @(posedge clk);
      #1;
      chk({cmd_done, ain_minmax_clr}, 2'b00);
    end
    send(rows[0].f, 1);
    chk(simple_cmd_en, 1'b1);
    rst();
    chk({simple_cmd_en, target_io2, cmd_done, cmd_status, last_cmd_code}, 0);
    close_out();
  end
endmodule
